// ===== logic/boot_retest_protection_control.sv
// Boot sequencer: configuration byte fetch, retest lockouts, protection reg
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Boot reads configuration from an NVM byte
// - Byte fetched from NVM address 0x0000
// - Config bits only ever go 0 to 1
// - No readback path for configuration bits
// - Bit 7 locks NVM on retest
// - Bit 6 locks EEPROM on retest
// - Bit 5 clears RAM on retest
// - Bit 4 enables crystal early, all levels
// - User load timed; oscillator overlaps it
// - User level, bit 1 clear: load, no run
// - User level, bit 1 set: autorun code
// - Boot loads protection register, readable
// - Software writes only set protection bits
// - Retest flags act only at run level
// - RAM clear zeros, keeps factory, low 8
// - EEPROM lockout sets EEPROM protection flag
// - NVM lockout sets protection flag at end
module boot_retest_protection_control #(
	parameter int LOAD_KB = 4,
	parameter int LOAD_CYC_PER_KB = boot_prot_pkg::LOAD_CYC_PER_KB,
	parameter int CODE_RAM_WORDS = 4096,
	parameter int FACTORY_WORDS = 256,
	parameter int IRAM_WORDS = 256
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] prog_level_i,
	input wire logic retest_seq_i,
	input wire logic [7:0] prot_level_seed_i,
	output logic nvm_rd_o,
	output logic [15:0] nvm_addr_o,
	input wire logic nvm_valid_i,
	input wire logic [7:0] nvm_data_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	output logic [7:0] chip_protection_register_o,
	output logic crystal_oscillator_en_o,
	output logic ram_wr_o,
	output logic ram_sel_iram_o,
	output logic [15:0] ram_addr_o,
	output logic [7:0] ram_wdata_o,
	output logic user_load_busy_o,
	output logic cpu_run_o,
	output logic debug_port_open_o,
	output logic boot_done_o
);
	typedef enum logic [6:0] {
		ST_FETCH = 7'b000_0001,
		ST_WAIT = 7'b000_0010,
		ST_DECIDE = 7'b000_0100,
		ST_CLR_CODE = 7'b000_1000,
		ST_CLR_IRAM = 7'b001_0000,
		ST_LOAD = 7'b010_0000,
		ST_DONE = 7'b100_0000
	} boot_state_t;

	localparam int LOAD_TOTAL = LOAD_KB * LOAD_CYC_PER_KB;

	nvm_req_if req_if ();

	nvm_fetch u_fetch (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.req_if(req_if),
		.nvm_rd_o(nvm_rd_o),
		.nvm_addr_o(nvm_addr_o),
		.nvm_valid_i(nvm_valid_i),
		.nvm_data_i(nvm_data_i)
	);

	boot_state_t state_ff, nxt_state;
	logic [7:0] cfg_ff, nxt_cfg;
	logic [7:0] prot_ff, nxt_prot;
	logic xtal_ff, nxt_xtal;
	logic ram_wr_ff, nxt_ram_wr;
	logic iram_ff, nxt_iram;
	logic [15:0] ram_addr_ff, nxt_ram_addr;
	logic [31:0] cnt_ff, nxt_cnt;
	logic run_ff, nxt_run;
	logic dbg_ff, nxt_dbg;
	logic done_ff, nxt_done;
	logic busy_ff, nxt_busy;
	logic [7:0] rdata_ff, nxt_rdata;
	logic retest_ff, nxt_retest;
	logic [2:0] level_ff, nxt_level;
	logic run_level;

	assign req_if.req = (state_ff == ST_FETCH);
	assign req_if.addr = boot_prot_pkg::CFG_BYTE_NVM_ADDR;
	assign run_level = (level_ff == boot_prot_pkg::LEVEL_RUN);

	always_comb begin
		nxt_state = state_ff;
		nxt_cfg = cfg_ff;
		nxt_prot = prot_ff;
		nxt_xtal = xtal_ff;
		nxt_ram_wr = 1'b0;
		nxt_iram = iram_ff;
		nxt_ram_addr = ram_addr_ff;
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		nxt_dbg = dbg_ff;
		nxt_done = done_ff;
		nxt_busy = 1'b0;
		nxt_retest = retest_ff;
		nxt_level = level_ff;
		nxt_rdata = rdata_ff;
		unique case (state_ff)
			ST_FETCH: begin
				nxt_level = prog_level_i;
				nxt_retest = retest_seq_i;
				nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (req_if.ack) begin
					// Reserved bits dropped on capture
					nxt_cfg = req_if.data & boot_prot_pkg::CFG_USED_MASK;
					nxt_state = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				nxt_xtal = cfg_ff[boot_prot_pkg::CFG_EARLY_XTAL_BIT];
				nxt_prot = prot_ff | prot_level_seed_i;
				nxt_ram_addr = 16'h0000;
				nxt_cnt = 32'h0000_0000;
				if (run_level && retest_ff) begin
					if (cfg_ff[boot_prot_pkg::CFG_EEPROM_LOCKOUT_BIT]) begin
						nxt_prot[boot_prot_pkg::PROT_EEPROM_BIT] = 1'b1;
					end
					if (cfg_ff[boot_prot_pkg::CFG_RAM_CLEAR_BIT]) begin
						nxt_iram = 1'b0;
						nxt_state = ST_CLR_CODE;
					end else begin
						nxt_state = ST_DONE;
					end
				end else if (level_ff == boot_prot_pkg::LEVEL_FACTORY) begin
					nxt_state = ST_DONE;
				end else begin
					nxt_state = ST_LOAD;
				end
			end
			ST_CLR_CODE: begin
				// Zero code/xdata up to the factory region at its top
				nxt_ram_wr = 1'b1;
				if (ram_wr_ff) begin
					if (ram_addr_ff == 16'(CODE_RAM_WORDS - FACTORY_WORDS - 1)) begin
						nxt_iram = 1'b1;
						nxt_ram_wr = 1'b0;
						nxt_ram_addr = 16'(boot_prot_pkg::IRAM_KEEP_REGS);
						nxt_state = ST_CLR_IRAM;
					end else begin
						nxt_ram_addr = ram_addr_ff + 16'h0001;
					end
				end
			end
			ST_CLR_IRAM: begin
				// Register bank 0 is kept
				nxt_ram_wr = 1'b1;
				if (ram_wr_ff) begin
					if (ram_addr_ff == 16'(IRAM_WORDS - 1)) begin
						nxt_ram_wr = 1'b0;
						nxt_state = ST_DONE;
					end else begin
						nxt_ram_addr = ram_addr_ff + 16'h0001;
					end
				end
			end
			ST_LOAD: begin
				nxt_busy = 1'b1;
				if (cnt_ff == 32'(LOAD_TOTAL - 1)) begin
					// Busy lags one cycle, so it covers the full load span
					nxt_state = ST_DONE;
				end else begin
					nxt_cnt = cnt_ff + 32'h0000_0001;
				end
			end
			ST_DONE: begin
				if (!done_ff) begin
					nxt_done = 1'b1;
					if (run_level && retest_ff &&
						cfg_ff[boot_prot_pkg::CFG_NVM_LOCKOUT_BIT]) begin
						nxt_prot[boot_prot_pkg::PROT_NVM_BIT] = 1'b1;
					end
					nxt_dbg = run_level && retest_ff;
					// Autorun only counts at user level
					nxt_run = (level_ff == boot_prot_pkg::LEVEL_USER) &&
						cfg_ff[boot_prot_pkg::CFG_AUTORUN_BIT];
				end
				if (sfr_wr_i && sfr_addr_i == boot_prot_pkg::PROT_ADDR) begin
					nxt_prot = nxt_prot |
						(sfr_wdata_i & boot_prot_pkg::PROT_WRITABLE_MASK);
				end
			end
			default: nxt_state = ST_FETCH;
		endcase
		if (sfr_rd_i) begin
			// Address 0xda shows protection only; config byte has no mirror
			nxt_rdata = (sfr_addr_i == boot_prot_pkg::PROT_ADDR) ?
				prot_ff : 8'h00;
		end
	end

	// Config register never written after capture, so bits cannot drop
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= ST_FETCH;
			cfg_ff <= boot_prot_pkg::CFG_BYTE_RESET;
			prot_ff <= boot_prot_pkg::PROT_RESET;
			xtal_ff <= 1'b0;
			ram_wr_ff <= 1'b0;
			iram_ff <= 1'b0;
			ram_addr_ff <= 16'h0000;
			cnt_ff <= 32'h0000_0000;
			run_ff <= 1'b0;
			dbg_ff <= 1'b0;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
			rdata_ff <= 8'h00;
			retest_ff <= 1'b0;
			level_ff <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			cfg_ff <= nxt_cfg;
			prot_ff <= nxt_prot;
			xtal_ff <= nxt_xtal;
			ram_wr_ff <= nxt_ram_wr;
			iram_ff <= nxt_iram;
			ram_addr_ff <= nxt_ram_addr;
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
			dbg_ff <= nxt_dbg;
			done_ff <= nxt_done;
			busy_ff <= nxt_busy;
			rdata_ff <= nxt_rdata;
			retest_ff <= nxt_retest;
			level_ff <= nxt_level;
		end
	end

	assign sfr_rdata_o = rdata_ff;
	assign chip_protection_register_o = prot_ff;
	assign crystal_oscillator_en_o = xtal_ff;
	assign ram_wr_o = ram_wr_ff;
	assign ram_sel_iram_o = iram_ff;
	assign ram_addr_o = ram_addr_ff;
	assign ram_wdata_o = 8'h00;
	assign user_load_busy_o = busy_ff;
	assign cpu_run_o = run_ff;
	assign debug_port_open_o = dbg_ff;
	assign boot_done_o = done_ff;
endmodule
`default_nettype wire

// ===== logic/boot_prot_pkg.sv
// Package: constants for boot-time protection and configuration loader
package boot_prot_pkg;
	// Configuration byte location and fields
	localparam logic [15:0] CFG_BYTE_NVM_ADDR = 16'h0000;
	localparam logic [7:0] CFG_BYTE_SFR_ADDR = 8'hda;
	localparam logic [7:0] CFG_BYTE_RESET = 8'h00;
	localparam int CFG_NVM_LOCKOUT_BIT = 7;
	localparam int CFG_EEPROM_LOCKOUT_BIT = 6;
	localparam int CFG_RAM_CLEAR_BIT = 5;
	localparam int CFG_EARLY_XTAL_BIT = 4;
	localparam int CFG_AUTORUN_BIT = 1;
	localparam logic [7:0] CFG_USED_MASK = 8'hf2;
	// Chip protection register fields
	localparam logic [7:0] PROT_ADDR = 8'hda;
	localparam logic [7:0] PROT_RESET = 8'h20;
	localparam int PROT_NVM_BIT = 7;
	localparam int PROT_DEBUG_OFF_BIT = 6;
	localparam int PROT_EEPROM_BIT = 4;
	localparam int PROT_NVM_WR_BIT = 3;
	localparam logic [7:0] PROT_WRITABLE_MASK = 8'hdf;
	// Programming levels
	localparam logic [2:0] LEVEL_FACTORY = 3'h1;
	localparam logic [2:0] LEVEL_USER = 3'h3;
	localparam logic [2:0] LEVEL_RUN = 3'h7;
	// Timing: load and settle times in microseconds, clock in MHz, cycle counts derived
	localparam int LOAD_US_PER_KB = 3600;
	localparam int XTAL_SETTLE_US = 10000;
	localparam int CLK_MHZ = 250;
	localparam int LOAD_CYC_PER_KB = LOAD_US_PER_KB * CLK_MHZ;
	localparam int XTAL_SETTLE_CYC = XTAL_SETTLE_US * CLK_MHZ;
	// RAM clear extent
	localparam int IRAM_KEEP_REGS = 8;
endpackage

// ===== logic/nvm_req_if.sv
// Interface: byte read channel from the loader to the NVM fetch unit
`timescale 1ns/1ps
`default_nettype none
interface nvm_req_if;
	logic req;
	logic [15:0] addr;
	logic ack;
	logic [7:0] data;
	modport master (output req, output addr, input ack, input data);
	modport slave (input req, input addr, output ack, output data);
endinterface
`default_nettype wire

// ===== logic/nvm_fetch.sv
// NVM fetch unit: one byte per request, read data registered
`timescale 1ns/1ps
`default_nettype none
module nvm_fetch (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	nvm_req_if.slave req_if,
	output logic nvm_rd_o,
	output logic [15:0] nvm_addr_o,
	input wire logic nvm_valid_i,
	input wire logic [7:0] nvm_data_i
);
	logic busy_ff;
	logic nxt_busy;
	logic ack_ff;
	logic nxt_ack;
	logic [7:0] data_ff;
	logic [7:0] nxt_data;
	logic [15:0] addr_ff;
	logic [15:0] nxt_addr;

	always_comb begin
		nxt_busy = busy_ff;
		nxt_ack = 1'b0;
		nxt_data = data_ff;
		nxt_addr = addr_ff;
		if (!busy_ff && req_if.req && !ack_ff) begin
			nxt_busy = 1'b1;
			nxt_addr = req_if.addr;
		end else if (busy_ff && nvm_valid_i) begin
			nxt_busy = 1'b0;
			nxt_ack = 1'b1;
			nxt_data = nvm_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_ff <= 1'b0;
			ack_ff <= 1'b0;
			data_ff <= 8'h00;
			addr_ff <= 16'h0000;
		end else begin
			busy_ff <= nxt_busy;
			ack_ff <= nxt_ack;
			data_ff <= nxt_data;
			addr_ff <= nxt_addr;
		end
	end

	assign req_if.ack = ack_ff;
	assign req_if.data = data_ff;
	assign nvm_rd_o = busy_ff;
	assign nvm_addr_o = addr_ff;
endmodule
`default_nettype wire

// ===== dv/boot_prot_properties.sv
// Checker: port properties of the boot protection block
`timescale 1ns/1ps
`default_nettype none
module boot_prot_properties (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic nvm_rd_o,
	input wire logic [15:0] nvm_addr_o,
	input wire logic nvm_valid_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic [7:0] chip_protection_register_o,
	input wire logic ram_wr_o,
	input wire logic ram_sel_iram_o,
	input wire logic [15:0] ram_addr_o,
	input wire logic [7:0] ram_wdata_o,
	input wire logic user_load_busy_o,
	input wire logic boot_done_o
);
	wire logic [7:0] prot = chip_protection_register_o;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence s_ack;
		nvm_rd_o && nvm_valid_i;
	endsequence
	sequence s_prot_wr;
		sfr_wr_i && sfr_addr_i == 8'hda && boot_done_o;
	endsequence
	nvm_addr_a: assert property (
		nvm_rd_o |-> nvm_addr_o == 16'h0000)
		else $error("fetch address wrong");
	rd_hold_a: assert property (
		nvm_rd_o && !nvm_valid_i |=> nvm_rd_o)
		else $error("fetch dropped early");
	rd_drop_a: assert property (
		s_ack |=> !nvm_rd_o ##1 !nvm_rd_o)
		else $error("fetch repeated");
	ram_zero_a: assert property (
		ram_wr_o |-> ram_wdata_o == 8'h00 &&
		!(ram_sel_iram_o && ram_addr_o < 16'h0008))
		else $error("bad clear write");
	prot_keep_a: assert property (
		1'b1 |=> ($past(prot) & ~prot) == 8'h00)
		else $error("protection bit cleared");
	prot_or_a: assert property (
		s_prot_wr |=> prot == ($past(prot) | ($past(sfr_wdata_i) & 8'hdf)))
		else $error("protection write wrong");
	read_map_a: assert property (
		sfr_rd_i |=> sfr_rdata_o ==
		($past(sfr_addr_i) == 8'hda ? $past(prot) : 8'h00))
		else $error("register read wrong");
	busy_gate_a: assert property (
		user_load_busy_o |-> !boot_done_o && !ram_wr_o)
		else $error("load overlaps completion");
endmodule
bind boot_retest_protection_control boot_prot_properties props_inst (
	.clk_i, .sys_rst_i, .nvm_rd_o, .nvm_addr_o, .nvm_valid_i, .sfr_wr_i,
	.sfr_rd_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o,
	.chip_protection_register_o, .ram_wr_o, .ram_sel_iram_o, .ram_addr_o,
	.ram_wdata_o, .user_load_busy_o, .boot_done_o);
`default_nettype wire

// ===== dv/nvm_model.sv
// Partner: NVM array holding the one-time configuration byte
`timescale 1ns/1ps
`default_nettype none
module nvm_model (
	input wire logic clk_i,
	input wire logic prog_i,
	input wire logic [7:0] prog_data_i,
	input wire logic [7:0] delay_i,
	input wire logic rd_i,
	input wire logic [15:0] addr_i,
	output logic valid_o,
	output logic [7:0] data_o
);
	logic [7:0] otp_ff = 8'h00;
	int wait_cnt = 0;
	initial valid_o = 1'b0;
	initial data_o = 8'h5a;
	always @(posedge clk_i) begin
		valid_o <= 1'b0;
		// Released data lines keep toggling
		data_o <= ~data_o;
		if (prog_i) otp_ff <= otp_ff | prog_data_i;
		wait_cnt <= 0;
		if (rd_i && !valid_o) begin
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= int'(delay_i)) begin
				valid_o <= 1'b1;
				data_o <= (addr_i == 16'h0000) ? otp_ff : 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Testbench: boot levels, retest lockouts, protection register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int KB = 4, CPK = 4, CODE = 16, FAC = 4, IRAM = 16;
	localparam int BUSY_N = KB * CPK, RAM_N = CODE - FAC + IRAM - 8;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, retest_seq_i = 1'b0;
	logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, prog = 1'b0;
	logic [2:0] prog_level_i = 3'h0;
	logic [7:0] prot_level_seed_i = 8'h00, sfr_addr_i = 8'h00;
	logic [7:0] sfr_wdata_i = 8'h00, prog_data = 8'h00, delay = 8'h00;
	logic nvm_rd_o, nvm_valid_i, crystal_oscillator_en_o, ram_wr_o;
	logic user_load_busy_o, cpu_run_o, debug_port_open_o, boot_done_o;
	logic [15:0] nvm_addr_o;
	logic [7:0] nvm_data_i, sfr_rdata_o, chip_protection_register_o;
	int n_mismatch = 0, cmp_count = 0, n_ram = 0, n_busy = 0;
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (ram_wr_o) n_ram++;
		if (user_load_busy_o) n_busy++;
	end
	boot_retest_protection_control #(.LOAD_KB(KB), .LOAD_CYC_PER_KB(CPK),
		.CODE_RAM_WORDS(CODE), .FACTORY_WORDS(FAC), .IRAM_WORDS(IRAM))
		boot_retest_protection_control_inst (
		.clk_i, .sys_rst_i, .prog_level_i, .retest_seq_i,
		.prot_level_seed_i, .nvm_rd_o, .nvm_addr_o, .nvm_valid_i,
		.nvm_data_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i,
		.sfr_rdata_o, .chip_protection_register_o,
		.crystal_oscillator_en_o, .ram_wr_o, .ram_sel_iram_o(),
		.ram_addr_o(), .ram_wdata_o(), .user_load_busy_o, .cpu_run_o,
		.debug_port_open_o, .boot_done_o);
	nvm_model nvm_model_inst (.clk_i, .prog_i(prog),
		.prog_data_i(prog_data), .delay_i(delay), .rd_i(nvm_rd_o),
		.addr_i(nvm_addr_o), .valid_o(nvm_valid_i), .data_o(nvm_data_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Reset, program more OTP bits, release and wait for completion
	task automatic boot(input logic [2:0] lvl, input logic rt,
		input logic [7:0] cfg, input logic [7:0] dly);
		@(negedge clk_i);
		sys_rst_i = 1'b1;
		prog_level_i = lvl;
		retest_seq_i = rt;
		prot_level_seed_i = {5'h00, lvl};
		delay = dly;
		prog_data = cfg;
		prog = 1'b1;
		@(negedge clk_i);
		prog = 1'b0;
		repeat (5) @(negedge clk_i);
		sys_rst_i = 1'b0;
		n_ram = 0;
		n_busy = 0;
		for (int i = 0; i < 300 && boot_done_o !== 1'b1; i++)
			@(negedge clk_i);
		chk(boot_done_o, 1'b1);
	endtask
	task automatic sfr(input logic w, input logic [7:0] a, d);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = w;
		sfr_rd_i = !w;
		@(negedge clk_i);
		sfr_wr_i = 1'b0;
		sfr_rd_i = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic s_user_hold;
		boot(3'h3, 1'b0, 8'h00, 8'h00);
		chk(cpu_run_o, 1'b0);
		chk(8'(n_busy), 8'(BUSY_N));
		chk(crystal_oscillator_en_o, 1'b0);
		chk(chip_protection_register_o, 8'h23);
	endtask
	task automatic s_factory_xtal;
		boot(3'h1, 1'b0, 8'h10, 8'h14);
		chk(crystal_oscillator_en_o, 1'b1);
		chk(8'(n_busy), 8'h00);
		chk(chip_protection_register_o, 8'h21);
	endtask
	task automatic s_user_flags;
		boot(3'h3, 1'b0, 8'h02, 8'h03);
		chk(cpu_run_o, 1'b1);
		boot(3'h3, 1'b1, 8'h2d, 8'h00);
		chk(chip_protection_register_o, 8'h23);
		chk(8'(n_ram), 8'h00);
		chk(debug_port_open_o, 1'b0);
	endtask
	task automatic s_run_retest;
		// OTP bits accumulate: add one retest flag per boot
		boot(3'h7, 1'b1, 8'h40, 8'h07);
		chk(chip_protection_register_o, 8'h37);
		chk(8'(n_ram), 8'h00);
		boot(3'h7, 1'b1, 8'h80, 8'h02);
		chk(chip_protection_register_o, 8'hb7);
		chk(8'(n_ram), 8'h00);
		boot(3'h7, 1'b1, 8'h22, 8'h00);
		chk(8'(n_ram), 8'(RAM_N));
		chk(debug_port_open_o, 1'b1);
		chk(cpu_run_o, 1'b0);
	endtask
	task automatic s_sfr_access;
		boot(3'h7, 1'b0, 8'h00, 8'h01);
		chk(8'(n_busy), 8'(BUSY_N));
		sfr(1'b1, 8'hda, 8'h00);
		sfr(1'b1, 8'h80, 8'h08);
		chk(chip_protection_register_o, 8'h27);
		sfr(1'b1, 8'hda, 8'h48);
		sfr(1'b0, 8'hda, 8'h00);
		chk(sfr_rdata_o, 8'h6f);
		sfr(1'b0, 8'h00, 8'h00);
		chk(sfr_rdata_o, 8'h00);
	endtask
	initial begin
		#40000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		s_user_hold();
		s_factory_xtal();
		s_run_retest();
		s_user_flags();
		s_sfr_access();
		finish_test();
	end
endmodule
`default_nettype wire
